// file: verilog/serial_port_pkg.sv
// Constants, register map and state encodings of the two-pin serial port
package serial_port_pkg;

  // ==========================================================================
  // Register byte offsets
  localparam logic [7:0] CMD_OFS    = 8'h00;
  localparam logic [7:0] FMT_OFS    = 8'h04;
  localparam logic [7:0] IEN_SET_OFS = 8'h08;
  localparam logic [7:0] IEN_CLR_OFS = 8'h0c;
  localparam logic [7:0] IEN_OFS    = 8'h10;
  localparam logic [7:0] FLAGS_OFS  = 8'h14;
  localparam logic [7:0] RX_CHR_OFS = 8'h18;
  localparam logic [7:0] TX_CHR_OFS = 8'h1c;
  localparam logic [7:0] DIV_OFS    = 8'h20;

  // ==========================================================================
  // Command bit positions
  localparam int RX_RST_BIT = 2;
  localparam int TX_RST_BIT = 3;
  localparam int RX_EN_BIT  = 4;
  localparam int RX_DIS_BIT = 5;
  localparam int TX_EN_BIT  = 6;
  localparam int TX_DIS_BIT = 7;
  localparam int STA_RST_BIT = 8;

  // ==========================================================================
  // Format field positions and encodings
  localparam int PAR_LSB = 9;
  localparam int CH_LSB  = 14;
  localparam logic [2:0] PAR_EVEN  = 3'h0;
  localparam logic [2:0] PAR_ODD   = 3'h1;
  localparam logic [2:0] PAR_SPACE = 3'h2;
  localparam logic [2:0] PAR_MARK  = 3'h3;
  localparam logic [2:0] PAR_NONE  = 3'h4;
  localparam logic [1:0] CH_NORMAL = 2'h0;
  localparam logic [1:0] CH_ECHO   = 2'h1;
  localparam logic [1:0] CH_LOCAL  = 2'h2;
  localparam logic [1:0] CH_REMOTE = 2'h3;

  // ==========================================================================
  // Flag bit positions, shared by flag, enable-set and enable-clear registers
  localparam int RX_READY_BIT = 0;
  localparam int TX_READY_BIT = 1;
  localparam int OVR_BIT   = 5;
  localparam int FRAME_BIT = 6;
  localparam int PERR_BIT  = 7;
  localparam int TXEMP_BIT = 9;
  localparam logic [9:0] FLAG_MASK = 10'h2e3;

  // ==========================================================================
  // Reset values and timing in sampling ticks
  localparam logic [2:0]  PAR_RESET = 3'h0;
  localparam logic [1:0]  CH_RESET  = 2'h0;
  localparam logic [15:0] DIV_RESET = 16'h0000;
  localparam logic [9:0]  MASK_RESET = 10'h000;
  localparam logic [4:0]  START_LOW_TICKS = 5'h07;
  localparam logic [4:0]  FIRST_SAMPLE    = 5'h18;
  localparam logic [4:0]  BIT_TICKS       = 5'h10;
  localparam logic [3:0]  TX_PHASE_LAST   = 4'hf;

  typedef enum logic [4:0] {
    RX_IDLE  = 5'b00001,
    RX_START = 5'b00010,
    RX_DATA  = 5'b00100,
    RX_PAR   = 5'b01000,
    RX_STOP  = 5'b10000
  } rx_state_e;

  typedef enum logic [4:0] {
    TX_IDLE  = 5'b00001,
    TX_START = 5'b00010,
    TX_DATA  = 5'b00100,
    TX_PAR   = 5'b01000,
    TX_STOP  = 5'b10000
  } tx_state_e;

endpackage : serial_port_pkg

// file: verilog/serial_port.sv
// Two-pin asynchronous serial port with baud generator, test paths and register port
//
// The implementer's own choice: strobed register access.

module serial_port (
  input  wire logic        clk,
  input  wire logic        arst_n,
  input  wire logic        clk_en,
  input  wire logic [7:0]  addr,
  input  wire logic [31:0] wdata,
  input  wire logic        wr,
  input  wire logic        rd,
  output logic      [31:0] rdata,
  input  wire logic        serial_in_pin,
  output logic             serial_out_pin,
  output logic             irq
);

  typedef struct packed {
    logic [2:0]                check_bit_type;
    logic [1:0]                test_path_select;
    logic [15:0]               baud_divisor;
    logic [9:0]                mask;
    logic [15:0]               div_cnt;
    logic                      sync1;
    logic                      sync2;
    logic                      rx_en;
    logic                      rx_dis_pend;
    serial_port_pkg::rx_state_e rx_st;
    logic [4:0]                rx_cnt;
    logic [2:0]                rx_idx;
    logic [7:0]                rx_shift;
    logic                      rx_par_bit;
    logic [7:0]                rhr;
    logic                      rx_ready;
    logic                      ovr;
    logic                      perr;
    logic                      frame;
    logic                      tx_en;
    logic                      tx_dis_pend;
    serial_port_pkg::tx_state_e tx_st;
    logic [3:0]                tx_phase;
    logic [2:0]                tx_idx;
    logic [7:0]                tx_shift;
    logic                      tx_par;
    logic [7:0]                thr;
    logic                      thr_full;
    logic                      tx_out;
    logic                      out_pin;
    logic                      irq;
    logic [31:0]               rdata;
  } state_s;

  state_s     q;
  state_s     n;
  logic       samp_tick;
  logic       tx_bit_tick;
  logic       rx_line;
  logic       rx_done;
  logic       cmd_wr;
  logic [9:0] flags;

  // Parity bit that accompanies a data byte for a given type
  function automatic logic parity_of(input logic [7:0] d, input logic [2:0] t);
    logic p;
    p = 1'b0;
    unique case (t)
      serial_port_pkg::PAR_EVEN:  p = ^d;
      serial_port_pkg::PAR_ODD:   p = ~^d;
      serial_port_pkg::PAR_SPACE: p = 1'b0;
      serial_port_pkg::PAR_MARK:  p = 1'b1;
      default:                    p = 1'b0;
    endcase
    return p;
  endfunction : parity_of

  // ==========================================================================
  // Next-state logic
  always_comb begin
    n           = q;
    samp_tick   = 1'b0;
    tx_bit_tick = 1'b0;
    rx_done     = 1'b0;
    cmd_wr      = wr && (addr == serial_port_pkg::CMD_OFS);
    flags       = 10'h000;
    flags[serial_port_pkg::RX_READY_BIT] = q.rx_ready;
    flags[serial_port_pkg::TX_READY_BIT] = q.tx_en && !q.thr_full;
    flags[serial_port_pkg::OVR_BIT]   = q.ovr;
    flags[serial_port_pkg::FRAME_BIT] = q.frame;
    flags[serial_port_pkg::PERR_BIT]  = q.perr;
    flags[serial_port_pkg::TXEMP_BIT] = q.tx_en && !q.thr_full && (q.tx_st == serial_port_pkg::TX_IDLE);

    n.sync1 = serial_in_pin;
    n.sync2 = q.sync1;
    // Local loop hides the pin from the receiver
    rx_line = (q.test_path_select == serial_port_pkg::CH_LOCAL) ? q.tx_out : q.sync2;

    // Sampling tick; remote loop also freezes both engines
    if (q.baud_divisor == 16'h0000 || q.test_path_select == serial_port_pkg::CH_REMOTE) begin
      n.div_cnt = 16'h0000;
    // A count left above a freshly lowered divisor ends the period at once
    end else if (q.div_cnt >= q.baud_divisor - 16'h0001) begin
      n.div_cnt = 16'h0000;
      samp_tick = 1'b1;
    end else begin
      n.div_cnt = q.div_cnt + 16'h0001;
    end

    // Register reads; read data is zero except the cycle after a read
    n.rdata = 32'h0000_0000;
    if (rd) begin
      unique case (addr)
        serial_port_pkg::FMT_OFS: begin
          n.rdata[serial_port_pkg::PAR_LSB +: 3] = q.check_bit_type;
          n.rdata[serial_port_pkg::CH_LSB +: 2]  = q.test_path_select;
        end
        serial_port_pkg::IEN_OFS:    n.rdata[9:0]  = q.mask;
        serial_port_pkg::FLAGS_OFS:  n.rdata[9:0]  = flags;
        serial_port_pkg::RX_CHR_OFS: begin
          n.rdata[7:0] = q.rhr;
          n.rx_ready   = 1'b0;
        end
        serial_port_pkg::DIV_OFS:    n.rdata[15:0] = q.baud_divisor;
        default:                     n.rdata = 32'h0000_0000;
      endcase
    end

    // Register writes
    if (wr) begin
      unique case (addr)
        serial_port_pkg::FMT_OFS: begin
          n.check_bit_type   = wdata[serial_port_pkg::PAR_LSB +: 3];
          n.test_path_select = wdata[serial_port_pkg::CH_LSB +: 2];
        end
        serial_port_pkg::IEN_SET_OFS: n.mask = q.mask | (wdata[9:0] & serial_port_pkg::FLAG_MASK);
        serial_port_pkg::IEN_CLR_OFS: n.mask = q.mask & ~(wdata[9:0] & serial_port_pkg::FLAG_MASK);
        serial_port_pkg::TX_CHR_OFS: begin
          if (q.tx_en) begin
            n.thr      = wdata[7:0];
            n.thr_full = 1'b1;
          end
        end
        serial_port_pkg::DIV_OFS: n.baud_divisor = wdata[15:0];
        default: ;
      endcase
    end
    if (cmd_wr && wdata[serial_port_pkg::STA_RST_BIT]) begin
      n.ovr   = 1'b0;
      n.perr  = 1'b0;
      n.frame = 1'b0;
    end

    // Enable and disable commands; disable beats enable
    if (cmd_wr) begin
      if (wdata[serial_port_pkg::RX_DIS_BIT]) begin
        if (q.rx_st == serial_port_pkg::RX_IDLE) begin
          n.rx_en = 1'b0;
        end else begin
          n.rx_dis_pend = 1'b1;
        end
      end else if (wdata[serial_port_pkg::RX_EN_BIT]) begin
        n.rx_en       = 1'b1;
        n.rx_dis_pend = 1'b0;
      end
      if (wdata[serial_port_pkg::TX_DIS_BIT]) begin
        n.tx_dis_pend = 1'b1;
      end else if (wdata[serial_port_pkg::TX_EN_BIT]) begin
        n.tx_en       = 1'b1;
        n.tx_dis_pend = 1'b0;
      end
    end

    // Receiver, advanced once per sampling tick
    if (samp_tick) begin
      unique case (q.rx_st)
        serial_port_pkg::RX_IDLE: begin
          if (q.rx_en && !rx_line && !q.rx_dis_pend) begin
            n.rx_st  = serial_port_pkg::RX_START;
            n.rx_cnt = 5'h00;
          end
        end
        serial_port_pkg::RX_START: begin
          n.rx_cnt = q.rx_cnt + 5'h01;
          if (rx_line) begin
            n.rx_st = serial_port_pkg::RX_IDLE;
          end else if (n.rx_cnt == serial_port_pkg::START_LOW_TICKS) begin
            n.rx_st  = serial_port_pkg::RX_DATA;
            n.rx_idx = 3'h0;
          end
        end
        serial_port_pkg::RX_DATA, serial_port_pkg::RX_PAR, serial_port_pkg::RX_STOP: begin
          n.rx_cnt = q.rx_cnt + 5'h01;
          if (n.rx_cnt == serial_port_pkg::FIRST_SAMPLE) begin
            // Rewind so the next sample lands one bit later
            n.rx_cnt = serial_port_pkg::FIRST_SAMPLE - serial_port_pkg::BIT_TICKS;
            if (q.rx_st == serial_port_pkg::RX_DATA) begin
              n.rx_shift = {rx_line, q.rx_shift[7:1]};
              n.rx_idx   = q.rx_idx + 3'h1;
              if (q.rx_idx == 3'h7) begin
                n.rx_st = (q.check_bit_type == serial_port_pkg::PAR_NONE) ?
                          serial_port_pkg::RX_STOP : serial_port_pkg::RX_PAR;
              end
            end else if (q.rx_st == serial_port_pkg::RX_PAR) begin
              n.rx_par_bit = rx_line;
              n.rx_st      = serial_port_pkg::RX_STOP;
            end else begin
              rx_done = 1'b1;
              n.rx_st = serial_port_pkg::RX_IDLE;
              n.rhr   = q.rx_shift;
              n.rx_ready = 1'b1;
              if (q.rx_ready) begin
                n.ovr = 1'b1;
              end
              if (q.check_bit_type != serial_port_pkg::PAR_NONE &&
                  q.rx_par_bit != parity_of(q.rx_shift, q.check_bit_type)) begin
                n.perr = 1'b1;
              end
              if (!rx_line) begin
                n.frame = 1'b1;
              end
            end
          end
        end
      endcase
    end
    if (n.rx_dis_pend && n.rx_st == serial_port_pkg::RX_IDLE) begin
      n.rx_en       = 1'b0;
      n.rx_dis_pend = 1'b0;
    end

    // Transmitter, one step per sixteen ticks
    if (samp_tick) begin
      n.tx_phase  = q.tx_phase + 4'h1;
      tx_bit_tick = (q.tx_phase == serial_port_pkg::TX_PHASE_LAST);
    end
    if (tx_bit_tick) begin
      unique case (q.tx_st)
        serial_port_pkg::TX_IDLE, serial_port_pkg::TX_STOP: begin
          n.tx_out = 1'b1;
          n.tx_st  = serial_port_pkg::TX_IDLE;
          if (q.tx_en && q.thr_full) begin
            n.tx_shift = q.thr;
            n.tx_par   = parity_of(q.thr, q.check_bit_type);
            n.thr_full = n.thr_full && (wr && addr == serial_port_pkg::TX_CHR_OFS);
            n.tx_st    = serial_port_pkg::TX_START;
            n.tx_out   = 1'b0;
          end
        end
        serial_port_pkg::TX_START: begin
          n.tx_out   = q.tx_shift[0];
          n.tx_shift = {1'b0, q.tx_shift[7:1]};
          n.tx_idx   = 3'h0;
          n.tx_st    = serial_port_pkg::TX_DATA;
        end
        serial_port_pkg::TX_DATA: begin
          n.tx_idx = q.tx_idx + 3'h1;
          if (q.tx_idx != 3'h7) begin
            n.tx_out   = q.tx_shift[0];
            n.tx_shift = {1'b0, q.tx_shift[7:1]};
          end else if (q.check_bit_type == serial_port_pkg::PAR_NONE) begin
            n.tx_out = 1'b1;
            n.tx_st  = serial_port_pkg::TX_STOP;
          end else begin
            n.tx_out = q.tx_par;
            n.tx_st  = serial_port_pkg::TX_PAR;
          end
        end
        serial_port_pkg::TX_PAR: begin
          n.tx_out = 1'b1;
          n.tx_st  = serial_port_pkg::TX_STOP;
        end
      endcase
    end
    if (n.tx_dis_pend && !n.thr_full && n.tx_st == serial_port_pkg::TX_IDLE) begin
      n.tx_en       = 1'b0;
      n.tx_dis_pend = 1'b0;
    end

    // Resets win over the states and enables the engines set this cycle
    if (cmd_wr && wdata[serial_port_pkg::RX_RST_BIT]) begin
      n.rx_st       = serial_port_pkg::RX_IDLE;
      n.rx_en       = 1'b0;
      n.rx_dis_pend = 1'b0;
    end
    if (cmd_wr && wdata[serial_port_pkg::TX_RST_BIT]) begin
      n.tx_st       = serial_port_pkg::TX_IDLE;
      n.tx_en       = 1'b0;
      n.tx_dis_pend = 1'b0;
      n.thr_full    = 1'b0;
      n.tx_out      = 1'b1;
    end

    // Output pin path
    unique case (q.test_path_select)
      serial_port_pkg::CH_NORMAL: n.out_pin = q.tx_out;
      serial_port_pkg::CH_ECHO:   n.out_pin = q.sync2;
      serial_port_pkg::CH_LOCAL:  n.out_pin = 1'b1;
      serial_port_pkg::CH_REMOTE: n.out_pin = q.sync2;
    endcase
    n.irq = |(flags & q.mask);
  end

  // ==========================================================================
  // State register
  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      q                  <= '0;
      q.check_bit_type   <= serial_port_pkg::PAR_RESET;
      q.test_path_select <= serial_port_pkg::CH_RESET;
      q.baud_divisor     <= serial_port_pkg::DIV_RESET;
      q.mask             <= serial_port_pkg::MASK_RESET;
      q.sync1            <= 1'b1;
      q.sync2            <= 1'b1;
      q.rx_st            <= serial_port_pkg::RX_IDLE;
      q.tx_st            <= serial_port_pkg::TX_IDLE;
      q.tx_out           <= 1'b1;
      q.out_pin          <= 1'b1;
    end else if (clk_en) begin
      q <= n;
    end
  end

  assign rdata          = q.rdata;
  assign serial_out_pin = q.out_pin;
  assign irq            = q.irq;

  // ==========================================================================
  // Assertions
  default clocking cb @(posedge clk); endclocking
  default disable iff (!arst_n);

  div_zero_idle_a: assert property (q.baud_divisor == 16'h0000 |-> !samp_tick)
    else $error("Tick with zero divisor");
  tick_spacing_a: assert property ((clk_en && samp_tick && q.baud_divisor == 16'h0002 && !wr) |=> !samp_tick)
    else $error("Ticks closer than divisor");
  rx_reset_a: assert property ((clk_en && cmd_wr && wdata[serial_port_pkg::RX_RST_BIT])
    |=> (q.rx_st == serial_port_pkg::RX_IDLE && !q.rx_en))
    else $error("Receiver reset ignored");
  rx_read_clr_a: assert property ((clk_en && rd && addr == serial_port_pkg::RX_CHR_OFS && !rx_done) |=> !q.rx_ready)
    else $error("Ready not cleared by read");
  overrun_set_a: assert property ((clk_en && rx_done && q.rx_ready) |=> q.ovr)
    else $error("Overrun missed");
  status_clr_a: assert property ((clk_en && cmd_wr && wdata[serial_port_pkg::STA_RST_BIT] && !rx_done)
    |=> !(q.ovr || q.perr || q.frame))
    else $error("Status reset failed");
  empty_real_a: assert property (flags[serial_port_pkg::TXEMP_BIT] |-> (!q.thr_full && q.tx_st == serial_port_pkg::TX_IDLE))
    else $error("Empty while busy");
  local_high_a: assert property ((clk_en && q.test_path_select == serial_port_pkg::CH_LOCAL) |=> serial_out_pin)
    else $error("Output not high in local loop");
  remote_path_a: assert property ((clk_en && q.test_path_select == serial_port_pkg::CH_REMOTE) |=> serial_out_pin == $past(q.sync2))
    else $error("Remote loop path broken");
  start_low_a: assert property ((q.tx_st == serial_port_pkg::TX_START) |-> !q.tx_out)
    else $error("Start bit not low");
  irq_mask_a: assert property ((clk_en && !(|(flags & q.mask))) |=> !irq)
    else $error("Interrupt without masked flag");

  rx_char_c:  cover property (rx_done);
  overrun_c:  cover property (rx_done && q.rx_ready);
  tx_empty_c: cover property ($rose(flags[serial_port_pkg::TXEMP_BIT]));
  loop_rx_c:  cover property (rx_done && q.test_path_select == serial_port_pkg::CH_LOCAL);

endmodule : serial_port

// file: verif/remote_node.sv
// Remote serial node model: drives the receive pin and decodes the transmit pin
module remote_node #(
  parameter int BIT = 16
) (
  input  wire logic clk,
  input  wire logic from_dut,
  output logic      to_dut
);
  timeunit 1ns;
  timeprecision 1ps;
  // ==========================================
  // Transmit side of the node
  initial to_dut = 1'b1;
  task automatic send(input logic [7:0] b, input logic has_p, input logic p, input logic stop);
    logic [10:0] f;
    @(posedge clk);
    f = has_p ? {stop, p, b, 1'b0} : {1'b1, stop, b, 1'b0};
    for (int i = 0; i < (has_p ? 11 : 10); i++) begin
      to_dut <= f[i];
      repeat (BIT) @(posedge clk);
    end
    // Line goes back to idle high, as the pull-up leaves it
    to_dut <= 1'b1;
  endtask : send
  task automatic glitch(input int n);
    @(posedge clk);
    to_dut <= 1'b0;
    repeat (n) @(posedge clk);
    to_dut <= 1'b1;
  endtask : glitch
  // ==========================================
  // Receive side: mid-bit sampling, returns in the middle of the stop bit
  task automatic recv(input logic has_p, output logic [7:0] b, output logic p, output logic stop);
    @(negedge from_dut);
    repeat (BIT / 2) @(posedge clk);
    for (int i = 0; i < 8; i++) begin
      repeat (BIT) @(posedge clk);
      b[i] = from_dut;
    end
    p = 1'b0;
    if (has_p) begin
      repeat (BIT) @(posedge clk);
      p = from_dut;
    end
    repeat (BIT) @(posedge clk);
    stop = from_dut;
  endtask : recv
endmodule : remote_node

// file: verif/tb_top.sv
// Bench: serial port against the remote node model and a queue reference
`define CHK(a, b) begin n_checks++; if ((a) !== (b)) begin mismatches++; \
  $display("CHECK FAILED t=%0t got %h exp %h", $time, (a), (b)); end end
module tb_top;
  timeunit 1ns;
  timeprecision 1ps;
  logic        clk, arst_n, wr, rd, s_in, s_out, irq, p, s, ce;
  logic [7:0]  addr, d, b;
  logic [31:0] wdata, rdata, v;
  logic [7:0]  exp_q[$];
  logic [7:0]  ofs[6] = '{8'h04, 8'h10, 8'h14, 8'h18, 8'h20, 8'h30};
  int          mismatches, n_checks, lows;

  serial_port i_serial_port (.clk(clk), .arst_n(arst_n), .clk_en(ce), .addr(addr), .wdata(wdata), .wr(wr),
    .rd(rd), .rdata(rdata), .serial_in_pin(s_in), .serial_out_pin(s_out), .irq(irq));
  remote_node #(.BIT(16)) i_remote_node (.clk(clk), .from_dut(s_out), .to_dut(s_in));

  initial begin
    clk = 1'b0;
    forever #12.5 clk = ~clk;
  end
  // ==========================================
  // Register port and reference helpers
  task automatic wreg(input logic [7:0] a, input logic [31:0] x);
    @(posedge clk);
    wr    <= 1'b1;
    addr  <= a;
    wdata <= x;
    @(posedge clk);
    wr <= 1'b0;
  endtask : wreg
  task automatic rreg(input logic [7:0] a);
    @(posedge clk);
    rd   <= 1'b1;
    addr <= a;
    @(posedge clk);
    rd <= 1'b0;
    @(negedge clk);
    v = rdata;
  endtask : rreg
  task automatic chk(input logic [7:0] a, input logic [31:0] m, input logic [31:0] e);
    rreg(a);
    `CHK(v & m, e)
  endtask : chk
  task automatic cmd(input int n);
    wreg(8'h00, 32'h1 << n);
  endtask : cmd
  task automatic flg(input logic [31:0] m, input logic [31:0] e);
    chk(8'h14, m, e);
  endtask : flg
  function automatic logic par_of(input logic [2:0] t, input logic [7:0] x);
    case (t)
      3'h0: return ^x;
      3'h1: return ~^x;
      3'h3: return 1'b1;
      default: return 1'b0;
    endcase
  endfunction : par_of
  // Even-parity frame from the node; pok low sends the wrong check bit
  task automatic rx(input logic [7:0] x, input logic pok, input logic stop);
    i_remote_node.send(x, 1'b1, par_of(3'h0, x) ^ ~pok, stop);
    repeat (24) @(posedge clk);
  endtask : rx
  task automatic end_sim;
    $display("checks %0d mismatches %0d", n_checks, mismatches);
    if (mismatches == 0 && n_checks > 0) $display("DONE - PASS");
    else $display("DONE - FAIL");
    $finish;
  endtask : end_sim
  // ==========================================
  // Tests
  initial begin
    void'($urandom(32'h9c1db21e));
    {arst_n, wr, rd, addr, wdata} = '0;
    ce = 1'b1;
    repeat (3) @(posedge clk);
    arst_n <= 1'b1;
    foreach (ofs[i]) chk(ofs[i], 32'hffffffff, 32'h0);
    cmd(4);
    i_remote_node.send(8'ha5, 1'b0, 1'b0, 1'b1);
    repeat (24) @(posedge clk);
    flg(32'h1, 32'h0);
    wreg(8'h20, 32'hffffffff);
    chk(8'h20, 32'hffffffff, 32'hffff);
    wreg(8'h20, 32'h2);
    repeat (8) @(posedge clk);
    wreg(8'h20, 32'h1);
    // A write while the clock enable is low must leave no trace
    ce <= 1'b0;
    wreg(8'h20, 32'h7);
    ce <= 1'b1;
    chk(8'h20, 32'hffffffff, 32'h1);
    cmd(6);
    flg(32'h2e3, 32'h202);
    wreg(8'h08, 32'hffffffff);
    chk(8'h10, 32'hffffffff, 32'h2e3);
    `CHK(irq, 1'b1)
    wreg(8'h0c, 32'h0e3);
    chk(8'h10, 32'hffffffff, 32'h200);
    wreg(8'h0c, 32'h200);
    repeat (2) @(negedge clk);
    `CHK(irq, 1'b0)
    $display("test registers done");
    for (int t = 0; t < 5; t++) begin
      wreg(8'h04, 32'(t) << 9);
      b = 8'($urandom);
      fork
        i_remote_node.recv(t != 4, d, p, s);
        wreg(8'h1c, {24'h0, b});
      join
      `CHK(d, b)
      `CHK(p, (t == 4) ? 1'b0 : par_of(3'(t), b))
      `CHK(s, 1'b1)
      flg(32'h200, 32'h0);
      repeat (16) @(posedge clk);
      flg(32'h202, 32'h202);
    end
    fork
      repeat (2) begin
        i_remote_node.recv(1'b0, d, p, s);
        b = exp_q.pop_front();
        `CHK(d, b)
      end
      begin
        for (int i = 0; i < 2; i++) begin
          exp_q.push_back(8'($urandom));
          wreg(8'h1c, {24'h0, exp_q[$]});
          repeat (20) @(posedge clk);
        end
        flg(32'h2, 32'h0);
        cmd(7);
      end
    join
    repeat (20) @(posedge clk);
    flg(32'h202, 32'h0);
    // Reset in mid-character: the line must return high and stay there
    cmd(6);
    wreg(8'h1c, 32'h0);
    repeat (40) @(posedge clk);
    cmd(3);
    repeat (2) @(posedge clk);
    lows = 0;
    repeat (180) @(negedge clk) lows += (s_out !== 1'b1);
    `CHK(lows, 0)
    wreg(8'h1c, 32'h0);
    cmd(6);
    flg(32'h202, 32'h202);
    $display("test transmit done");
    wreg(8'h04, 32'h0);
    b = 8'($urandom);
    rx(b, 1'b1, 1'b1);
    flg(32'he1, 32'h01);
    chk(8'h18, 32'hff, {24'h0, b});
    flg(32'h1, 32'h0);
    rx(8'h3c, 1'b0, 1'b1);
    flg(32'he1, 32'h81);
    rx(8'h0f, 1'b1, 1'b0);
    flg(32'he1, 32'he1);
    chk(8'h18, 32'hff, 32'h0f);
    // A low stop bit may start a stray frame; let it finish before clearing
    repeat (250) @(posedge clk);
    cmd(8);
    rreg(8'h18);
    flg(32'he1, 32'h0);
    i_remote_node.glitch(7);
    repeat (250) @(posedge clk);
    flg(32'h1, 32'h0);
    b = 8'($urandom);
    fork
      rx(b, 1'b1, 1'b1);
      begin
        repeat (40) @(posedge clk);
        cmd(5);
      end
    join
    chk(8'h18, 32'hff, {24'h0, b});
    rx(8'h5a, 1'b1, 1'b1);
    flg(32'h1, 32'h0);
    cmd(4);
    fork
      rx(8'h5a, 1'b1, 1'b1);
      begin
        repeat (40) @(posedge clk);
        cmd(2);
      end
    join
    flg(32'h1, 32'h0);
    $display("test receive done");
    cmd(4);
    cmd(6);
    wreg(8'h04, 32'h8800);
    b = 8'($urandom);
    lows = 0;
    fork
      wreg(8'h1c, {24'h0, b});
      repeat (220) @(negedge clk) lows += (s_out !== 1'b1);
    join
    `CHK(lows, 0)
    chk(8'h18, 32'hff, {24'h0, b});
    for (int m = 1; m < 4; m += 2) begin
      wreg(8'h04, 32'h800 | (32'(m) << 14));
      b = 8'($urandom);
      fork
        i_remote_node.send(b, 1'b0, 1'b0, 1'b1);
        i_remote_node.recv(1'b0, d, p, s);
      join
      `CHK(d, b)
      repeat (24) @(posedge clk);
      flg(32'h1, (m == 1) ? 32'h1 : 32'h0);
      rreg(8'h18);
    end
    $display("test modes done");
    end_sim();
  end
  // Watchdog: the tests need well under 10000 cycles
  initial begin
    repeat (40000) @(posedge clk);
    mismatches++;
    end_sim();
  end
endmodule : tb_top
